// ===== ops_pkg.sv
package ops_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_HZ = 40_000_000;
   localparam int CLK_MHZ = CLK_HZ / 1_000_000;
   localparam int OSC_HZ = 100_000;
   localparam int PERIOD_CYC = CLK_HZ / OSC_HZ;
   localparam int PH_W = 9;
   // Sawtooth ramp: maximum on-time is half the period
   localparam int MAX_DUTY_PCT = 50;
   localparam int MAX_ON_CYC = PERIOD_CYC * MAX_DUTY_PCT / 100;
   localparam int MIN_ON_NS = 200;
   localparam int MIN_ON_CYC = (MIN_ON_NS * CLK_MHZ + 999) / 1000;
   localparam int LEB_NS = 150;
   localparam int LEB_CYC = (LEB_NS * CLK_MHZ + 999) / 1000;
   localparam logic [PH_W-1:0] PH_LAST = PH_W'(PERIOD_CYC - 1);
   localparam logic [PH_W-1:0] PH_MAX_ON = PH_W'(MAX_ON_CYC);
   localparam logic [PH_W-1:0] PH_MIN_ON = PH_W'(MIN_ON_CYC);
   localparam logic [PH_W-1:0] PH_LEB = PH_W'(LEB_CYC);

   // ----------------------------------------------------------------
   // Error signal and auto-restart
   // ----------------------------------------------------------------
   localparam int ERR_W = 8;
   localparam logic [ERR_W-1:0] ERR_DEAD = 8'h20;
   localparam int CNT_W = 3;
   localparam logic [CNT_W-1:0] CNT_LAST = 3'h7;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam int AW = 12;
   localparam logic [AW-1:0] ADDR_CTRL = 12'h000;
   localparam logic [AW-1:0] ADDR_STATUS = 12'h004;
   localparam logic [AW-1:0] ADDR_IRQ_STAT = 12'h008;
   localparam logic [AW-1:0] ADDR_IRQ_CLR = 12'h00C;
   localparam logic [AW-1:0] ADDR_IRQ_EN = 12'h010;
   localparam int CTRL_RUN_BIT = 0;
   localparam logic CTRL_RUN_RST = 1'b1;
   localparam int ST_STATE_LSB = 0;
   localparam int ST_CNT_LSB = 4;
   localparam int ST_OVP_BIT = 7;
   localparam int ST_OTP_BIT = 8;
   localparam int ST_GATE_BIT = 9;
   localparam int ST_HV_BIT = 10;
   localparam int EV_W = 5;
   localparam int EV_RUN = 0;
   localparam int EV_RESTART = 1;
   localparam int EV_OCP = 2;
   localparam int EV_OVP = 3;
   localparam int EV_OTP = 4;
   localparam logic [EV_W-1:0] IRQ_EN_RST = 5'h00;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_START = 4'b0001,
      ST_RUN = 4'b0010,
      ST_RESTART = 4'b0100,
      ST_LATCH = 4'b1000
   } ops_state_type;

   typedef struct packed {
      logic vc_upper;
      logic vc_lower;
      logic drain_trip;
      logic ctrl_surge;
      logic over_temp;
   } ops_sense_type;

   typedef struct packed {
      logic gate;
      logic hv_bias;
      logic standby;
   } ops_drive_type;

endpackage : ops_pkg

// ===== ops_switch_ctrl.sv
`timescale 1ns/1ps
// Contract
// RQ1 - First upper supply threshold: bias source off, modulator and switch enabled.
// RQ2 - Supply at lower threshold: switch off, standby, bias source on again.
// RQ3 - Hysteretic mode: bias on at lower threshold, off at upper threshold.
// RQ4 - Restart counter holds switch off for eight discharge-charge cycles.
// RQ5 - Auto-restart repeats while regulation is lost; normal operation resumes afterwards.
// RQ6 - Each oscillator period start sets the latch, turning the switch on.
// RQ7 - Modulator resets latch at error-over-sawtooth crossing; more current, shorter pulse.
// RQ8 - On-time never exceeds the oscillator-defined maximum duty limit.
// RQ9 - Minimum on-time always; duty falls only above a minimum control current. Current limit can still end a pulse at blanking end, before it.
// RQ10 - Drain voltage comparator trip turns switch off until next period.
// RQ11 - Current-limit comparator ignored during blanking interval after turn-on.
// RQ12 - Control-pin surge sets overvoltage latch, holding the switch off.
// RQ13 - Shutdown latch clears only on power-up reset.
// RQ14 - Auto-restart and latched shutdown keep supply in hysteretic regulation.
// RQ15 - Overtemperature latches switch off until power-up reset.
// RQ16 - Bias source stays off during normal switching.
// RQ17 - Power-up reset clears counter and latches, switch off, start-up with bias on.
module ops_switch_ctrl (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ops_pkg::AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input ops_pkg::ops_sense_type sense,
   input wire logic [ops_pkg::ERR_W-1:0] err_level,
   output ops_pkg::ops_drive_type drive,
   output logic irq
);
   import ops_pkg::*;

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   ops_state_type state_r, state_nxt;
   ops_drive_type drive_r, drive_nxt;
   logic [PH_W-1:0] phase_r;
   logic [CNT_W-1:0] cnt_r, cnt_nxt;
   logic ovp_r, otp_r;
   logic ctrl_run_r;
   logic [EV_W-1:0] ist_r, ien_r;
   logic irq_r;
   logic [31:0] prdata_r;
   logic pready_r, pslverr_r;
   logic gate_nxt;
   logic hv_nxt;

   function automatic logic [PH_W-1:0] on_limit(input logic [ERR_W-1:0] err);
      logic [PH_W-1:0] excess;
      excess = (err > ERR_DEAD) ? {1'b0, err - ERR_DEAD} : '0;
      if (excess >= PH_MAX_ON - PH_MIN_ON)
      begin
         on_limit = PH_MIN_ON;
      end
      else
      begin
         on_limit = PH_MAX_ON - excess;
      end
   endfunction : on_limit

   // ----------------------------------------------------------------
   // Supply sequencing
   // ----------------------------------------------------------------
   wire fault_now = sense.ctrl_surge | sense.over_temp | ovp_r | otp_r;
   wire hyst_mode = (state_r == ST_RESTART) || (state_r == ST_LATCH);
   wire charge_done = sense.vc_upper & ~sense.vc_lower;

   always_comb
   begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      hv_nxt = drive_r.hv_bias;
      case (state_r)
         ST_START:
         begin
            hv_nxt = 1'b1;
            if (fault_now)
            begin
               state_nxt = ST_LATCH;
            end
            else if (charge_done)
            begin
               state_nxt = ST_RUN; // RQ1
               hv_nxt = 1'b0; // RQ1
            end
         end
         ST_RUN:
         begin
            hv_nxt = 1'b0; // RQ16
            if (fault_now)
            begin
               state_nxt = ST_LATCH; // RQ12 RQ15
            end
            else if (sense.vc_lower)
            begin
               state_nxt = ST_RESTART; // RQ2
               cnt_nxt = '0;
               hv_nxt = 1'b1; // RQ2
            end
         end
         ST_RESTART, ST_LATCH:
         begin
            // Same window in both modes
            if (sense.vc_lower)
            begin
               hv_nxt = 1'b1; // RQ3 RQ14
            end
            else if (sense.vc_upper)
            begin
               hv_nxt = 1'b0; // RQ3 RQ14
            end
            if (state_r == ST_RESTART)
            begin
               if (fault_now)
               begin
                  state_nxt = ST_LATCH;
               end
               else if (charge_done && drive_r.hv_bias)
               begin
                  // One completed discharge-charge cycle
                  if (cnt_r == CNT_LAST)
                  begin
                     state_nxt = ST_RUN; // RQ5
                     cnt_nxt = '0;
                  end
                  else
                  begin
                     cnt_nxt = cnt_r + 3'h1; // RQ4
                  end
               end
            end
         end
         default:
         begin
            state_nxt = ST_START;
            hv_nxt = 1'b1;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Oscillator and PWM latch
   // ----------------------------------------------------------------
   wire switch_ok = (state_r == ST_RUN) && (state_nxt == ST_RUN) && ctrl_run_r;
   wire period_start = (phase_r == '0);
   wire [PH_W-1:0] pwm_lim = on_limit(err_level); // RQ9
   wire blank_over = (phase_r >= PH_LEB); // RQ11
   wire ocp_cut = drive_r.gate & sense.drain_trip & blank_over; // RQ10 RQ11
   wire pwm_cut = (phase_r >= pwm_lim) && (phase_r >= PH_MIN_ON); // RQ7 RQ9
   wire max_cut = (phase_r >= PH_MAX_ON); // RQ8
   wire early_cut = ~switch_ok | ocp_cut;

   always_comb
   begin
      if (!switch_ok)
      begin
         gate_nxt = 1'b0; // RQ4 RQ12 RQ15
      end
      else if (period_start)
      begin
         gate_nxt = 1'b1; // RQ6
      end
      else if (max_cut || ocp_cut || pwm_cut)
      begin
         gate_nxt = 1'b0; // RQ7 RQ8 RQ10
      end
      else
      begin
         gate_nxt = drive_r.gate;
      end
   end

   always_comb
   begin
      drive_nxt.gate = gate_nxt;
      drive_nxt.hv_bias = hv_nxt;
      drive_nxt.standby = (state_nxt != ST_RUN); // RQ2
   end

   // ----------------------------------------------------------------
   // Events and interrupt
   // ----------------------------------------------------------------
   wire [EV_W-1:0] ev;
   assign ev[EV_RUN] = (state_r != ST_RUN) && (state_nxt == ST_RUN);
   assign ev[EV_RESTART] = (state_r != ST_RESTART) && (state_nxt == ST_RESTART);
   assign ev[EV_OCP] = ocp_cut;
   assign ev[EV_OVP] = sense.ctrl_surge & ~ovp_r;
   assign ev[EV_OTP] = sense.over_temp & ~otp_r;

   // ----------------------------------------------------------------
   // APB slave
   // ----------------------------------------------------------------
   wire acc = psel & penable;
   wire acc_first = acc & ~pready_r;
   wire hit_ctrl = (paddr == ADDR_CTRL);
   wire hit_status = (paddr == ADDR_STATUS);
   wire hit_ist = (paddr == ADDR_IRQ_STAT);
   wire hit_iclr = (paddr == ADDR_IRQ_CLR);
   wire hit_ien = (paddr == ADDR_IRQ_EN);
   wire mapped = hit_ctrl | hit_status | hit_ist | hit_iclr | hit_ien;
   wire wr_go = acc & pready_r & pwrite;
   wire [EV_W-1:0] clr_mask = (wr_go && hit_iclr) ? pwdata[EV_W-1:0] : '0;
   // Set wins over a clear in the same cycle
   wire [EV_W-1:0] ist_nxt = (ist_r & ~clr_mask) | ev;
   wire [EV_W-1:0] ien_nxt = (wr_go && hit_ien) ? pwdata[EV_W-1:0] : ien_r;

   wire [31:0] status_word = (32'(state_r) << ST_STATE_LSB) | (32'(cnt_r) << ST_CNT_LSB)
      | (32'(ovp_r) << ST_OVP_BIT) | (32'(otp_r) << ST_OTP_BIT)
      | (32'(drive_r.gate) << ST_GATE_BIT) | (32'(drive_r.hv_bias) << ST_HV_BIT);
   wire [31:0] rd_mux = hit_ctrl ? (32'(ctrl_run_r) << CTRL_RUN_BIT)
      : hit_status ? status_word
      : hit_ist ? 32'(ist_r)
      : hit_ien ? 32'(ien_r)
      : 32'h0000_0000;

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_r <= ST_START; // RQ17
         cnt_r <= '0; // RQ17
         drive_r <= 3'b011; // RQ17
         ovp_r <= 1'b0; // RQ13 RQ17
         otp_r <= 1'b0; // RQ17
         phase_r <= '0;
      end
      else
      begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         drive_r <= drive_nxt;
         ovp_r <= ovp_r | sense.ctrl_surge; // RQ12 RQ13
         otp_r <= otp_r | sense.over_temp; // RQ15
         phase_r <= (phase_r == PH_LAST) ? '0 : phase_r + 9'h001; // RQ6
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_run_r <= CTRL_RUN_RST;
         ist_r <= '0;
         ien_r <= IRQ_EN_RST;
         irq_r <= 1'b0;
      end
      else
      begin
         if (wr_go && hit_ctrl)
         begin
            ctrl_run_r <= pwdata[CTRL_RUN_BIT];
         end
         ist_r <= ist_nxt;
         ien_r <= ien_nxt;
         irq_r <= |(ist_nxt & ien_nxt);
      end
   end

   // One wait state, answer registered
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
      end
      else
      begin
         pready_r <= acc_first;
         pslverr_r <= acc_first & ~mapped;
         prdata_r <= (acc_first && !pwrite) ? rd_mux : 32'h0000_0000;
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign drive = drive_r;
   assign irq = irq_r;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_drop;
      (state_r == ST_RUN) ##1 (state_r == ST_RESTART);
   endsequence

   sequence s_cut;
      ocp_cut && (phase_r < PH_LAST);
   endsequence

   sequence s_ovp_set;
      sense.ctrl_surge ##1 ovp_r;
   endsequence

   sequence s_gate_idle;
      !drive_r.gate && (phase_r != '0);
   endsequence

   AST_START_RUN: assert property ((state_r == ST_START) && charge_done && !fault_now // RQ1
      |=> (state_r == ST_RUN) && !drive_r.hv_bias && !drive_r.standby)
      else $error("start-up did not hand over to switching");
   AST_DROP: assert property (s_drop |-> drive_r.hv_bias && drive_r.standby && !drive_r.gate) // RQ2
      else $error("lower threshold did not stop switching");
   AST_HYST_ON: assert property (hyst_mode && sense.vc_lower |=> drive_r.hv_bias) // RQ3
      else $error("bias source not enabled at lower threshold");
   AST_HYST_OFF: assert property (hyst_mode && charge_done |=> !drive_r.hv_bias) // RQ14
      else $error("bias source not disabled at upper threshold");
   AST_RESTART_OFF: assert property (state_r == ST_RESTART |-> !drive_r.gate) // RQ4
      else $error("switch on during auto-restart");
   AST_COUNT: assert property ((state_r == ST_RESTART) && charge_done && drive_r.hv_bias // RQ4
      && !fault_now && (cnt_r != CNT_LAST) |=> cnt_r == $past(cnt_r) + 3'h1)
      else $error("restart counter did not advance");
   AST_RESUME: assert property ((state_r == ST_RESTART) && charge_done && drive_r.hv_bias // RQ5
      && !fault_now && (cnt_r == CNT_LAST) |=> (state_r == ST_RUN) && (cnt_r == '0))
      else $error("no resume after eighth cycle");
   AST_SET: assert property (switch_ok && period_start |=> drive_r.gate) // RQ6
      else $error("latch not set at period start");
   AST_PWM: assert property (switch_ok && drive_r.gate && pwm_cut |=> !drive_r.gate) // RQ7
      else $error("modulator did not end pulse");
   AST_MAXON: assert property (drive_r.gate |-> (phase_r != '0) && (phase_r <= PH_MAX_ON)) // RQ8
      else $error("on-time beyond maximum duty");
   AST_MINON: assert property ($fell(drive_r.gate) && !$past(early_cut) |-> phase_r > PH_MIN_ON) // RQ9
      else $error("pulse shorter than minimum on-time");
   AST_OCP: assert property (s_cut |=> !drive_r.gate) // RQ10
      else $error("current limit did not turn switch off");
   AST_BLANK: assert property (switch_ok && drive_r.gate && !blank_over && !pwm_cut && !max_cut // RQ11
      |=> drive_r.gate)
      else $error("pulse ended during blanking");
   AST_OVP: assert property (s_ovp_set |=> ovp_r && !drive_r.gate && (state_r == ST_LATCH)) // RQ12
      else $error("overvoltage latch not holding switch off");
   AST_OVP_HOLD: assert property (ovp_r |=> ovp_r) // RQ13
      else $error("overvoltage latch cleared without reset");
   AST_OTP: assert property (sense.over_temp |=> otp_r && !drive_r.gate && (state_r == ST_LATCH)) // RQ15
      else $error("overtemperature did not latch off");
   AST_HV_RUN: assert property (state_r == ST_RUN |-> !drive_r.hv_bias) // RQ16
      else $error("bias source on while switching");
   AST_IRQ: assert property (irq_r == |(ist_r & ien_r))
      else $error("interrupt level disagrees with status");

   AST_STANDBY: assert property (drive_r.standby == (state_r != ST_RUN)) // RQ2
      else $error("standby does not follow switching state");
   AST_OFF_HOLD: assert property (s_gate_idle |=> !drive_r.gate) // RQ10
      else $error("switch turned on outside period start");
   AST_LATCH_OFF: assert property (state_r == ST_LATCH |-> !drive_r.gate) // RQ12
      else $error("switch on while latched off");
   AST_LATCH_STAY: assert property (state_r == ST_LATCH |=> state_r == ST_LATCH) // RQ13
      else $error("latched shutdown left without reset");
   AST_OTP_HOLD: assert property (otp_r |=> otp_r) // RQ15
      else $error("overtemperature latch cleared without reset");
   AST_START_BIAS: assert property (state_r == ST_START |-> drive_r.hv_bias && !drive_r.gate) // RQ17
      else $error("bias source off or switch on during start-up");
   // Bus answer shape
   AST_READY_ONE: assert property (pready_r |=> !pready_r)
      else $error("bus answer stood longer than one cycle");
   AST_ERR_READY: assert property (pslverr_r |-> pready_r)
      else $error("error response without ready");

endmodule : ops_switch_ctrl

// ===== ops_supply_model.sv
`timescale 1ns/1ps
module ops_supply_model (
   input wire logic pclk,
   input wire logic presetn,
   input ops_pkg::ops_drive_type drive,
   input wire logic regulated,
   input wire logic [8:0] trip_at,
   output logic vc_upper,
   output logic vc_lower,
   output logic drain_trip
);
   import ops_pkg::*;

   // ----------------------------------------------------------------
   // Supply capacitor and drain current sense
   // ----------------------------------------------------------------
   logic [5:0] vc_r;
   logic [5:0] vc_nxt;
   logic [8:0] on_r;
   logic [8:0] on_nxt;
   logic fb;

   // Feedback current only exists while the switch is running
   assign fb = regulated && !drive.standby;
   assign vc_nxt = drive.hv_bias ? ((vc_r == 6'h28) ? vc_r : vc_r + 6'h01)
                 : ((fb || vc_r == 6'h00) ? vc_r : vc_r - 6'h01);
   assign vc_upper = (vc_r >= 6'h1E);
   assign vc_lower = (vc_r <= 6'h0A);
   assign on_nxt = drive.gate ? on_r + 9'h001 : 9'h000;
   // Comparator reads low whenever the switch is off
   assign drain_trip = drive.gate && (trip_at != 9'h000) && (on_r >= trip_at);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         vc_r <= 6'h00;
         on_r <= 9'h000;
      end
      else
      begin
         vc_r <= vc_nxt;
         on_r <= on_nxt;
      end
   end
endmodule : ops_supply_model

// ===== offline_pwm_switch_controller_tb.sv
`timescale 1ns/1ps
module offline_pwm_switch_controller_tb;
   import ops_pkg::*;

   // ----------------------------------------------------------------
   // Clock, bench state and instances
   // ----------------------------------------------------------------
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [AW-1:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   ops_sense_type sense;
   logic [ERR_W-1:0] err_level = 8'h00;
   ops_drive_type drive;
   logic irq;
   logic vc_up;
   logic vc_lo;
   logic trip;
   logic surge = 1'b0;
   logic hot = 1'b0;
   logic regulated = 1'b1;
   logic [8:0] trip_at = 9'h000;
   logic [31:0] rd;
   logic er;
   int mismatches = 0;
   int n_checks = 0;
   int w;
   int p;
   int k;
   int wn;

   always #12.5 pclk = ~pclk;
   assign sense = {vc_up, vc_lo, trip, surge, hot};

   ops_switch_ctrl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sense(sense),
      .err_level(err_level), .drive(drive), .irq(irq));
   ops_supply_model i_far (.pclk(pclk), .presetn(presetn), .drive(drive), .regulated(regulated),
      .trip_at(trip_at), .vc_upper(vc_up), .vc_lower(vc_lo), .drain_trip(trip));

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task stop_test;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : stop_test

   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : chk

   task apb(input logic wr, input logic [AW-1:0] a, input logic [31:0] wd);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task wait_drv(input int b, input logic v);
      wn = 0;
      while (drive[b] !== v && wn < 3000)
      begin
         @(posedge pclk);
         wn++;
      end
      if (wn >= 3000)
      begin
         mismatches++;
         $display("unexpected at %0t: drive bit %0d stuck", $time, b);
         stop_test();
      end
   endtask : wait_drv

   task pwm(input logic [7:0] e, input logic [8:0] t, input int exp_w);
      err_level <= e;
      trip_at <= t;
      wait_drv(2, 1'b0);
      wait_drv(2, 1'b1);
      wait_drv(2, 1'b0);
      w = wn;
      wait_drv(2, 1'b1);
      p = w + wn;
      chk(w, exp_w);
      chk(p, PERIOD_CYC);
      chk(drive.hv_bias, 1'b0);
   endtask : pwm

   // Counts bias turn-offs and gate-high cycles, optionally up to a gate rise
   task scan(input int n, input logic stop);
      int i;
      logic q;
      w = 0;
      k = 0;
      q = drive.hv_bias;
      for (i = 0; i < n && !(stop && drive.gate === 1'b1); i++)
      begin
         @(posedge pclk);
         if (drive.gate === 1'b1)
            k++;
         if (q === 1'b1 && drive.hv_bias === 1'b0)
            w++;
         q = drive.hv_bias;
      end
   endtask : scan

   // ----------------------------------------------------------------
   // Test sequence
   // ----------------------------------------------------------------
   initial
   begin
      repeat (60000) @(posedge pclk);
      mismatches++;
      stop_test();
   end

   initial
   begin
      repeat (2) @(posedge pclk);
      chk(drive, 3'b011);
      presetn <= 1'b1;
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(rd[3:0], ST_START);
      chk(er, 1'b0);
      wait_drv(1, 1'b0);
      chk(drive.standby, 1'b0);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(rd[3:0], ST_RUN);
      apb(1'b0, ADDR_IRQ_STAT, 32'h0);
      chk(rd[EV_RUN], 1'b1);
      chk(irq, 1'b0);
      pwm(8'h00, 9'h000, MAX_ON_CYC);
      pwm(ERR_DEAD, 9'h000, MAX_ON_CYC);
      pwm(ERR_DEAD + 8'h32, 9'h000, MAX_ON_CYC - 50);
      pwm(8'hFF, 9'h000, MIN_ON_CYC);
      apb(1'b1, ADDR_IRQ_EN, 32'h1 << EV_OCP);
      pwm(8'h00, 9'h002, LEB_CYC);
      pwm(8'h00, 9'h014, 21);
      trip_at <= 9'h000;
      chk(irq, 1'b1);
      apb(1'b1, ADDR_IRQ_CLR, 32'h0000_001F);
      repeat (2) @(posedge pclk);
      chk(irq, 1'b0);
      apb(1'b0, ADDR_IRQ_EN, 32'h0);
      chk(rd, 32'h1 << EV_OCP);
      apb(1'b0, 12'h014, 32'h0);
      chk(er, 1'b1);
      chk(rd, 32'h0000_0000);
      // Loss of regulation: supply sags and restart begins
      regulated <= 1'b0;
      wait_drv(0, 1'b1);
      chk(drive, 3'b011);
      regulated <= 1'b1;
      scan(3000, 1'b1);
      chk(w, CNT_LAST + 1);
      pwm(8'h00, 9'h000, MAX_ON_CYC);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(rd[3:0], ST_RUN);
      apb(1'b1, ADDR_CTRL, 32'h0);
      scan(500, 1'b0);
      chk(k, 0);
      chk(drive.hv_bias, 1'b0);
      apb(1'b0, ADDR_CTRL, 32'h0);
      chk(rd, 32'h0000_0000);
      apb(1'b1, ADDR_CTRL, 32'h1);
      wait_drv(2, 1'b1);
      chk(drive.gate, 1'b1);
      surge <= 1'b1;
      @(posedge pclk);
      surge <= 1'b0;
      regulated <= 1'b0;
      repeat (2) @(posedge pclk);
      chk(drive.gate, 1'b0);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(rd[ST_OVP_BIT], 1'b1);
      chk(rd[3:0], ST_LATCH);
      scan(1000, 1'b0);
      chk(k, 0);
      chk(w >= 20, 1'b1);
      presetn <= 1'b0;
      regulated <= 1'b1;
      repeat (2) @(posedge pclk);
      chk(drive, 3'b011);
      presetn <= 1'b1;
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(rd[8:4], 5'h00);
      wait_drv(2, 1'b1);
      apb(1'b1, ADDR_IRQ_EN, 32'h1 << EV_OTP);
      hot <= 1'b1;
      @(posedge pclk);
      hot <= 1'b0;
      repeat (2) @(posedge pclk);
      chk(drive.gate, 1'b0);
      chk(irq, 1'b1);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(rd[ST_OTP_BIT], 1'b1);
      scan(1000, 1'b0);
      chk(k, 0);
      chk(w >= 20, 1'b1);
      stop_test();
   end
endmodule : offline_pwm_switch_controller_tb
